// ==== hw/rphe_pkg.sv ====
// package: constants and types for the root-port hot-plug event block
`default_nettype none
package rphe_pkg;
	// --------------------------------------------------------------
	// clock and timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int L1_EXIT_SRIS_US = 10;
	localparam int L1_EXIT_SRIS_CYC = (L1_EXIT_SRIS_US * 1000) / CLK_PERIOD_NS;
	// --------------------------------------------------------------
	// clock tolerance and advertised latency encodings
	// --------------------------------------------------------------
	localparam logic [12:0] PPM_COMMON = 13'h0258;
	localparam logic [12:0] PPM_SRIS = 13'h15e0;
	localparam logic [2:0] L1_EXIT_COMMON = 3'h6;
	localparam logic [2:0] L1_EXIT_SRIS = 3'h7;
	// --------------------------------------------------------------
	// lanes and controller configurations
	// --------------------------------------------------------------
	localparam int NUM_LANES = 4;
	localparam logic [1:0] CFG_1X4 = 2'h0;
	localparam logic [1:0] CFG_2X1_1X2 = 2'h1;
	localparam logic [1:0] CFG_4X1 = 2'h2;
	localparam logic [1:0] CFG_2X2 = 2'h3;
	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam logic RST_FLAG = 1'b0;
	localparam logic [NUM_LANES-1:0] RST_LANES = 4'h0;
	// per-lane training progress
	typedef enum logic [1:0] {
		RPHE_LN_IDLE,
		RPHE_LN_TRAIN,
		RPHE_LN_DONE
	} rphe_lane_st_t;
endpackage
`default_nettype wire

// ==== hw/rphe_lane_pol.sv ====
// per-lane receiver polarity detector and corrector
`default_nettype none
module rphe_lane_pol
	import rphe_pkg::*;
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic trainStart,
	input  wire logic symValid,
	input  wire logic symInverted,
	input  wire logic symNormal,
	input  wire logic rxBitRaw,
	output logic      rxBit,
	output logic      invert,
	output logic      trained
);
	rphe_lane_st_t st_q, st_d;
	logic          inv_q, inv_d;
	logic          bit_q;

	// --------------------------------------------------------------
	// training: inversion is latched only while training, no config
	// --------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		inv_d = inv_q;
		case (st_q)
			RPHE_LN_IDLE: begin
				if (trainStart) begin
					st_d = RPHE_LN_TRAIN;
					inv_d = 1'b0;
				end
			end
			RPHE_LN_TRAIN: begin
				if (symValid && symInverted) begin
					inv_d = 1'b1;
					st_d = RPHE_LN_DONE;
				end else if (symValid && symNormal) begin
					st_d = RPHE_LN_DONE;
				end
			end
			RPHE_LN_DONE: begin
				// a new training restarts detection
				if (trainStart) begin
					st_d = RPHE_LN_TRAIN;
					inv_d = 1'b0;
				end
			end
			default: st_d = RPHE_LN_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= RPHE_LN_IDLE;
			inv_q <= RST_FLAG;
			bit_q <= RST_FLAG;
		end else begin
			st_q <= st_d;
			inv_q <= inv_d;
			bit_q <= rxBitRaw ^ inv_d;
		end
	end

	assign rxBit = bit_q;
	assign invert = inv_q;
	assign trained = (st_q == RPHE_LN_DONE);

	a_pol_latched: assert property (@(posedge clk) disable iff (!rstn)
		(st_q == RPHE_LN_TRAIN && symValid && symInverted) |=> (invert && trained))
		else $error("inversion not latched");
endmodule
`default_nettype wire

// ==== hw/rphe_hotplug.sv ====
// root-port hot-plug events, sris straps, lane reversal and system_error_out_n paths
`default_nettype none
module rphe_hotplug
	import rphe_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 phyPresent,
	input  wire logic                 linkActive,
	input  wire logic                 presence_change_irq_en,
	input  wire logic                 hotplug_irq_en,
	input  wire logic                 hotplug_sci_en,
	input  wire logic                 hotplug_smi_en,
	input  wire logic                 clrPresenceChanged,
	input  wire logic                 clrSciStatus,
	input  wire logic                 clrSmiPresence,
	input  wire logic                 clrSmiLinkActive,
	input  wire logic                 srisStrap,
	input  wire logic                 aspmL0sReq,
	input  wire logic                 lowerSkpReq,
	input  wire logic [1:0]           laneCfg,
	input  wire logic                 laneReverseReq,
	input  wire logic [NUM_LANES-1:0] txLaneData,
	input  wire logic [NUM_LANES-1:0] rxLaneRaw,
	input  wire logic                 trainStart,
	input  wire logic [NUM_LANES-1:0] symValid,
	input  wire logic [NUM_LANES-1:0] symInverted,
	input  wire logic [NUM_LANES-1:0] symNormal,
	input  wire logic                 hdrSerrEn,
	input  wire logic                 hdrErrEvent,
	input  wire logic                 capSerrEn,
	input  wire logic                 capErrEvent,
	output logic                      presence_state,
	output logic                      presence_changed,
	output logic                      hotplugIrq,
	output logic                      hotplug_sci_status,
	output logic                      smi_presence_changed,
	output logic                      smi_link_active_changed,
	output logic                      smi_out_n,
	output logic                      srisMode,
	output logic [12:0]               ppmTolerance,
	output logic                      aspmL0sEnable,
	output logic [2:0]                l1ExitLatency,
	output logic                      lowerSkpEnable,
	output logic                      laneReversed,
	output logic [NUM_LANES-1:0]      txLaneOut,
	output logic [NUM_LANES-1:0]      rxLaneData,
	output logic [NUM_LANES-1:0]      laneInverted,
	output logic [NUM_LANES-1:0]      laneTrained,
	output logic                      system_error_out_n
);
	logic presState_q, presChg_q, sciSts_q, smiPres_q, smiLink_q;
	logic prevPhy_q, prevLink_q, strapDone_q, sris_q, rev_q, system_error_out_n_q;
	logic [NUM_LANES-1:0] txOut_q, rxRev_q, rxFixed;

	// --------------------------------------------------------------
	// event detection
	// --------------------------------------------------------------
	wire insertEv = phyPresent && !prevPhy_q;
	wire removeEv = !phyPresent && prevPhy_q;
	wire presEv = insertEv || removeEv;
	wire linkEv = linkActive ^ prevLink_q;
	wire irqGate = presence_change_irq_en && hotplug_irq_en;
	wire sciEv = hotplug_sci_en && ((presEv && irqGate) || linkEv);
	// set wins over clear on every sticky flag
	wire presChg_d = presEv || (presChg_q && !clrPresenceChanged);
	wire sciSts_d = sciEv || (sciSts_q && !clrSciStatus);
	wire smiPres_d = (hotplug_smi_en && presEv) || (smiPres_q && !clrSmiPresence);
	wire smiLink_d = (hotplug_smi_en && linkEv) || (smiLink_q && !clrSmiLinkActive);
	wire presState_d = insertEv ? 1'b1 : (removeEv ? 1'b0 : presState_q);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prevPhy_q <= RST_FLAG;
			prevLink_q <= RST_FLAG;
			presState_q <= RST_FLAG;
			presChg_q <= RST_FLAG;
			sciSts_q <= RST_FLAG;
			smiPres_q <= RST_FLAG;
			smiLink_q <= RST_FLAG;
		end else begin
			prevPhy_q <= phyPresent;
			prevLink_q <= linkActive;
			presState_q <= presState_d;
			presChg_q <= presChg_d;
			sciSts_q <= sciSts_d;
			smiPres_q <= smiPres_d;
			smiLink_q <= smiLink_d;
		end
	end

	assign presence_state = presState_q;
	assign presence_changed = presChg_q;
	assign hotplugIrq = presChg_q && irqGate;
	assign hotplug_sci_status = sciSts_q;
	assign smi_presence_changed = smiPres_q;
	assign smi_link_active_changed = smiLink_q;
	assign smi_out_n = !(smiPres_q || smiLink_q);

	// --------------------------------------------------------------
	// sris strap: caught once after reset release, then frozen
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strapDone_q <= RST_FLAG;
			sris_q <= RST_FLAG;
		end else if (!strapDone_q) begin
			strapDone_q <= 1'b1;
			sris_q <= srisStrap;
		end
	end

	assign srisMode = sris_q;
	assign ppmTolerance = sris_q ? PPM_SRIS : PPM_COMMON;
	assign aspmL0sEnable = aspmL0sReq && !sris_q;
	assign l1ExitLatency = sris_q ? L1_EXIT_SRIS : L1_EXIT_COMMON;
	// request ignored: the port neither sends nor takes lower skp sets
	assign lowerSkpEnable = 1'b0 && lowerSkpReq;

	// --------------------------------------------------------------
	// lane reversal and per-lane polarity
	// --------------------------------------------------------------
	function automatic logic [NUM_LANES-1:0] rev4(input logic [NUM_LANES-1:0] v);
		rev4 = {v[0], v[1], v[2], v[3]};
	endfunction

	wire revOk = (laneCfg == CFG_1X4) || (laneCfg == CFG_2X1_1X2);

	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++) begin : gLane
			rphe_lane_pol uPol (
				.clk         (clk),
				.rstn        (rstn),
				.trainStart  (trainStart),
				.symValid    (symValid[g]),
				.symInverted (symInverted[g]),
				.symNormal   (symNormal[g]),
				.rxBitRaw    (rxLaneRaw[g]),
				.rxBit       (rxFixed[g]),
				.invert      (laneInverted[g]),
				.trained     (laneTrained[g])
			);
		end
	endgenerate

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rev_q <= RST_FLAG;
			txOut_q <= RST_LANES;
			rxRev_q <= RST_LANES;
		end else begin
			rev_q <= laneReverseReq && revOk;
			txOut_q <= rev_q ? rev4(txLaneData) : txLaneData;
			rxRev_q <= rev_q ? rev4(rxFixed) : rxFixed;
		end
	end

	assign laneReversed = rev_q;
	assign txLaneOut = txOut_q;
	assign rxLaneData = rxRev_q;

	// --------------------------------------------------------------
	// system error: header path or capability path
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			system_error_out_n_q <= RST_FLAG;
		end else begin
			system_error_out_n_q <= (hdrSerrEn && hdrErrEvent) || (capSerrEn && capErrEvent);
		end
	end

	assign system_error_out_n = !system_error_out_n_q;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	sequence sInsert;
		!prevPhy_q ##0 phyPresent;
	endsequence

	a_insert_sets: assert property (@(posedge clk) disable iff (!rstn)
		sInsert |=> (presence_state && presence_changed))
		else $error("insertion did not set presence bits");
	a_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
		hotplugIrq |-> (presence_change_irq_en && hotplug_irq_en && presence_changed))
		else $error("interrupt without both enables");
	a_irq_raise: assert property (@(posedge clk) disable iff (!rstn)
		(presEv && irqGate) ##1 irqGate |-> hotplugIrq)
		else $error("interrupt not raised on presence change");
	a_remove_clears: assert property (@(posedge clk) disable iff (!rstn)
		(prevPhy_q && !phyPresent) |=> (!presence_state && presence_changed))
		else $error("removal handling wrong");
	a_sci_status: assert property (@(posedge clk) disable iff (!rstn)
		(hotplug_sci_en && linkEv) |=> hotplug_sci_status)
		else $error("sci status not set");
	a_smi_link: assert property (@(posedge clk) disable iff (!rstn)
		(hotplug_smi_en && linkEv) |=> smi_link_active_changed)
		else $error("smi link bit not set");
	a_smi_out: assert property (@(posedge clk) disable iff (!rstn)
		(hotplug_smi_en && presEv) |=> !smi_out_n)
		else $error("smi output not asserted");
	a_smi_indep: assert property (@(posedge clk) disable iff (!rstn)
		(hotplug_smi_en && presEv && !hotplug_sci_en && !irqGate) |=> smi_presence_changed)
		else $error("smi bit gated by other enables");
	a_strap_static: assert property (@(posedge clk) disable iff (!rstn)
		strapDone_q |=> $stable(srisMode))
		else $error("sris mode changed after strap");
	a_sris_nol0s: assert property (@(posedge clk) disable iff (!rstn)
		srisMode |-> (!aspmL0sEnable && l1ExitLatency == L1_EXIT_SRIS))
		else $error("sris limits broken");
	a_no_lowskp: assert property (@(posedge clk) disable iff (!rstn)
		!lowerSkpEnable)
		else $error("lower skp enabled");
	a_rev_cfg: assert property (@(posedge clk) disable iff (!rstn)
		laneReversed |-> $past(revOk))
		else $error("reversal in unsupported config");
	a_rev_map: assert property (@(posedge clk) disable iff (!rstn)
		laneReversed |=> (txLaneOut[0] == $past(txLaneData[3])
			&& txLaneOut[1] == $past(txLaneData[2])
			&& txLaneOut[2] == $past(txLaneData[1])
			&& txLaneOut[3] == $past(txLaneData[0])))
		else $error("reversal mapping wrong");
	a_system_error_out_n_paths: assert property (@(posedge clk) disable iff (!rstn)
		((hdrSerrEn && hdrErrEvent) || (capSerrEn && capErrEvent)) |=> !system_error_out_n)
		else $error("system error not asserted");
endmodule
`default_nettype wire

// ==== dv/rphe_ep_model.sv ====
// behavioural far-side module: presence, link and training symbols
`default_nettype none
module rphe_ep_model
	import rphe_pkg::*;
#(
	parameter int SYM_DELAY = 3
) (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 plugCmd,
	input  wire logic                 linkCmd,
	input  wire logic                 trainStart,
	input  wire logic [NUM_LANES-1:0] polFlip,
	input  wire logic [NUM_LANES-1:0] dataCmd,
	output logic                      phyPresent,
	output logic                      linkActive,
	output logic [NUM_LANES-1:0]      rxLaneRaw,
	output logic [NUM_LANES-1:0]      symValid,
	output logic [NUM_LANES-1:0]      symInverted,
	output logic [NUM_LANES-1:0]      symNormal
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] symCnt_q;
	wire        symNow = (symCnt_q == 4'h1);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phyPresent  <= 1'b0;
			linkActive  <= 1'b0;
			symCnt_q    <= 4'h0;
			symValid    <= 4'h0;
			symInverted <= 4'h0;
			symNormal   <= 4'h0;
			rxLaneRaw   <= 4'h0;
		end else begin
			phyPresent  <= plugCmd;
			// link only comes up while a module sits in the slot
			linkActive  <= linkCmd & phyPresent;
			if (trainStart)
				symCnt_q <= 4'(SYM_DELAY);
			else if (symCnt_q != 4'h0)
				symCnt_q <= symCnt_q - 4'h1;
			symValid    <= symNow ? 4'hf : 4'h0;
			// outside the symbol slot the type lines carry the opposite pattern
			symInverted <= symNow ? polFlip : ~polFlip;
			symNormal   <= symNow ? ~polFlip : polFlip;
			// a crossed pair delivers every bit inverted
			rxLaneRaw   <= dataCmd ^ polFlip;
		end
	end
endmodule
`default_nettype wire

// ==== dv/tb_rphe_hotplug.sv ====
// self-checking bench for the root-port hot-plug event block
`default_nettype none
module tb_rphe_hotplug
	import rphe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, plugCmd, linkCmd, trainStart, srisStrap, aspmL0sReq, lowerSkpReq;
	logic        presence_change_irq_en, hotplug_irq_en, hotplug_sci_en, hotplug_smi_en;
	logic        clrPresenceChanged, clrSciStatus, clrSmiPresence, clrSmiLinkActive;
	logic        hdrSerrEn, hdrErrEvent, capSerrEn, capErrEvent, phyPresent, linkActive;
	logic        laneReverseReq, presence_state, presence_changed, hotplugIrq;
	logic        hotplug_sci_status, smi_presence_changed, smi_link_active_changed, smi_out_n;
	logic        srisMode, aspmL0sEnable, lowerSkpEnable, laneReversed, system_error_out_n;
	logic [1:0]  laneCfg;
	logic [2:0]  l1ExitLatency;
	logic [3:0]  txLaneData, rxLaneRaw, symValid, symInverted, symNormal, polFlip, dataCmd;
	logic [3:0]  txLaneOut, rxLaneData, laneInverted, laneTrained;
	logic [12:0] ppmTolerance;
	int          errorCnt, testsRun, cycles;
	// row: enables {pde,hpe,sci,smi}, then expected {irq,sci,smi}
	localparam logic [6:0] ROWS [8] = '{7'h64, 7'h40, 7'h20, 7'h76, 7'h19, 7'h7f, 7'h09,
		7'h50};

	rphe_hotplug i_rphe_hotplug (.clk, .rstn, .phyPresent, .linkActive, .presence_change_irq_en,
		.hotplug_irq_en, .hotplug_sci_en, .hotplug_smi_en, .clrPresenceChanged, .clrSciStatus,
		.clrSmiPresence, .clrSmiLinkActive, .srisStrap, .aspmL0sReq, .lowerSkpReq, .laneCfg,
		.laneReverseReq, .txLaneData, .rxLaneRaw, .trainStart, .symValid, .symInverted,
		.symNormal, .hdrSerrEn, .hdrErrEvent, .capSerrEn, .capErrEvent, .presence_state,
		.presence_changed, .hotplugIrq, .hotplug_sci_status, .smi_presence_changed,
		.smi_link_active_changed, .smi_out_n, .srisMode, .ppmTolerance, .aspmL0sEnable,
		.l1ExitLatency, .lowerSkpEnable, .laneReversed, .txLaneOut, .rxLaneData,
		.laneInverted, .laneTrained, .system_error_out_n);
	rphe_ep_model i_rphe_ep_model (.clk, .rstn, .plugCmd, .linkCmd, .trainStart, .polFlip,
		.dataCmd, .phyPresent, .linkActive, .rxLaneRaw, .symValid, .symInverted, .symNormal);

	always #25 clk = ~clk;
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp) begin
			errorCnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic clearAll();
		{clrPresenceChanged, clrSciStatus, clrSmiPresence, clrSmiLinkActive} = 4'hf;
		tick(1);
		{clrPresenceChanged, clrSciStatus, clrSmiPresence, clrSmiLinkActive} = 4'h0;
	endtask
	task automatic printVerdict();
		$display("checks=%0d errors=%0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// hang guard: the whole run needs well under 500 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errorCnt++;
			printVerdict();
		end
	end
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		{clk, rstn, plugCmd, linkCmd, trainStart, srisStrap, aspmL0sReq, lowerSkpReq} = '0;
		{presence_change_irq_en, hotplug_irq_en, hotplug_sci_en, hotplug_smi_en} = '0;
		{clrPresenceChanged, clrSciStatus, clrSmiPresence, clrSmiLinkActive} = '0;
		{hdrSerrEn, hdrErrEvent, capSerrEn, capErrEvent, laneReverseReq, laneCfg} = '0;
		{txLaneData, polFlip, dataCmd} = '0;
		{errorCnt, testsRun, cycles} = '0;
		tick(16);
		rstn = 1'b1;
		aspmL0sReq = 1'b1;
		lowerSkpReq = 1'b1;
		tick(2);
		chk(srisMode, 1'b0);
		chk(ppmTolerance, PPM_COMMON);
		chk(l1ExitLatency, L1_EXIT_COMMON);
		chk(aspmL0sEnable, 1'b1);
		chk(lowerSkpEnable, 1'b0);
		chk(smi_out_n, 1'b1);
		for (int r = 0; r < 8; r++) begin
			{presence_change_irq_en, hotplug_irq_en, hotplug_sci_en, hotplug_smi_en} = ROWS[r][6:3];
			clearAll();
			plugCmd = !plugCmd;
			tick(4);
			chk(presence_state, plugCmd);
			chk(presence_changed, 1'b1);
			chk(hotplugIrq, ROWS[r][2]);
			chk(hotplug_sci_status, ROWS[r][1]);
			chk(smi_presence_changed, ROWS[r][0]);
			chk(smi_out_n, !ROWS[r][0]);
		end
		// link change: sets sci and its own smi bit, with both irq enables off
		{presence_change_irq_en, hotplug_irq_en, hotplug_sci_en, hotplug_smi_en} = 4'h3;
		clearAll();
		plugCmd = 1'b1;
		tick(4);
		chk(hotplug_sci_status, 1'b0);
		linkCmd = 1'b1;
		tick(4);
		chk(smi_link_active_changed, 1'b1);
		chk(hotplug_sci_status, 1'b1);
		{clrPresenceChanged, clrSmiPresence} = 2'h3;
		tick(1);
		{clrPresenceChanged, clrSmiPresence} = 2'h0;
		tick(2);
		chk(presence_changed, 1'b0);
		chk(smi_out_n, 1'b0);
		clrSmiLinkActive = 1'b1;
		tick(1);
		clrSmiLinkActive = 1'b0;
		tick(2);
		chk(smi_out_n, 1'b1);
		// lane reversal over every controller configuration
		laneReverseReq = 1'b1;
		txLaneData = 4'hb;
		for (int c = 0; c < 4; c++) begin
			laneCfg = c[1:0];
			tick(4);
			chk(laneReversed, c < 2);
			chk(txLaneOut, (c < 2) ? 4'hd : 4'hb);
		end
		// polarity: lanes 0 and 2 crossed
		laneReverseReq = 1'b0;
		polFlip = 4'h5;
		dataCmd = 4'h3;
		trainStart = 1'b1;
		tick(1);
		trainStart = 1'b0;
		tick(10);
		chk(laneInverted, 4'h5);
		chk(laneTrained, 4'hf);
		chk(rxLaneData, 4'h3);
		laneReverseReq = 1'b1;
		laneCfg = CFG_1X4;
		tick(4);
		chk(rxLaneData, 4'hc);
		for (int i = 0; i < 16; i++) begin
			{hdrSerrEn, hdrErrEvent, capSerrEn, capErrEvent} = i[3:0];
			tick(2);
			chk(system_error_out_n, !((i[3] & i[2]) | (i[1] & i[0])));
		end
		// second reset with the strap set, then a late strap change
		rstn = 1'b0;
		srisStrap = 1'b1;
		tick(2);
		chk(system_error_out_n, 1'b1);
		chk(presence_changed, 1'b0);
		rstn = 1'b1;
		tick(1);
		srisStrap = 1'b0;
		tick(2);
		chk(srisMode, 1'b1);
		chk(ppmTolerance, PPM_SRIS);
		chk(l1ExitLatency, L1_EXIT_SRIS);
		chk(aspmL0sEnable, 1'b0);
		chk(lowerSkpEnable, 1'b0);
		printVerdict();
	end
endmodule
`default_nettype wire
